/* rtl/traffic_generator.sv */
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - read requests never exceed 512 bytes
// - write payloads never exceed 128 bytes
// - paired read/write sizes from fixed table
// - ratio one-one: one read outstanding
// - ratio one-four: one read, four writes
// - ratio four-sixteen: four tagged reads outstanding
// - ratio sixteen-sixtyfour: sixteen tagged reads outstanding
// - cycle mode replays programmed passes, then stops
// - loop count is sixteen bits wide
// - throughput mode loops until software stops
// - programmed idle gap between passes
// - count sent writes and elapsed cycles
// - count completions and record timestamp
// - software can clear performance counters
// - count cycles blocked on non-posted credit
// - count cycles blocked on posted credit
// - completions stored with timestamp in queue
// - writes go to host, reads fetch
// - cycle passes carry reads, writes or both
module traffic_generator #(
  parameter int RXQ_DEPTH_LOG = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_is_write,
  output logic [9:0] tx_bytes,
  output logic [3:0] tx_tag,
  output logic [31:0] tx_addr,
  input wire logic np_credit_ok,
  input wire logic p_credit_ok,
  input wire logic cpl_valid,
  input wire logic cpl_final,
  input wire logic [31:0] cpl_data,
  output logic test_running
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum logic [1:0] {IDLE, ISSUE, GAP} gen_state_t;

  typedef struct packed {
    gen_state_t state;
    logic busy;
    logic run;
    logic thru;
    logic [1:0] mix;
    logic [2:0] size;
    logic [1:0] ratio;
    logic [15:0] loops;
    logic [15:0] gap;
    logic [15:0] pass_len;
    logic [31:0] base;
    logic done;
    logic [15:0] loops_done;
    logic [15:0] gap_cnt;
    logic [15:0] grp_left;
    logic [15:0] wr_left;
    logic rd_due;
    logic [4:0] outst;
    logic [3:0] tag;
    logic [31:0] addr_off;
    logic tx_valid;
    logic tx_is_write;
    logic [9:0] tx_bytes;
    logic [3:0] tx_tag;
    logic [31:0] tx_addr;
    logic [31:0] sent;
    logic [31:0] rcvd;
    logic [31:0] elapsed;
    logic [31:0] np_wait;
    logic [31:0] p_wait;
    logic [31:0] stamp;
    logic [31:0] rdata;
  } gen_st_t;

  gen_st_t st_q;
  gen_st_t st_d;
  logic ctrl_wr;
  logic clear;
  logic accept;
  logic rd_done;
  logic rxq_pop;
  logic [31:0] head_data;
  logic [31:0] head_stamp;
  logic [RXQ_DEPTH_LOG:0] rxq_level;

  // read requests allowed in flight per ratio
  function automatic logic [4:0] read_limit(input logic [1:0] r);
    unique case (traffic_generator_pkg::ratio_t'(r))
      traffic_generator_pkg::ratio_one_one: read_limit =
        traffic_generator_pkg::LIMIT_ONE;
      traffic_generator_pkg::ratio_one_four: read_limit =
        traffic_generator_pkg::LIMIT_ONE;
      traffic_generator_pkg::ratio_four_sixteen: read_limit =
        traffic_generator_pkg::LIMIT_FOUR;
      traffic_generator_pkg::ratio_sixteen_sixtyfour: read_limit =
        traffic_generator_pkg::LIMIT_SIXTEEN;
    endcase
  endfunction

  // writes following each read in combined operation
  function automatic logic [15:0] writes_per_group(input logic [1:0] r);
    if (traffic_generator_pkg::ratio_t'(r) ==
        traffic_generator_pkg::ratio_one_one)
      writes_per_group = traffic_generator_pkg::WR_PER_GROUP_ONE;
    else
      writes_per_group = traffic_generator_pkg::WR_PER_GROUP_FOUR;
  endfunction

  // load one pass of the pattern queue
  function automatic gen_st_t start_pass(input gen_st_t s);
    gen_st_t t;
    t = s;
    t.state = ISSUE;
    t.addr_off = '0;
    unique case (traffic_generator_pkg::tlp_mix_t'(s.mix))
      traffic_generator_pkg::MIX_WRITE:
      begin
        t.grp_left = 16'h0001;
        t.rd_due = 1'b0;
        t.wr_left = s.pass_len;
      end
      traffic_generator_pkg::MIX_BOTH:
      begin
        t.grp_left = 16'(read_limit(s.ratio));
        t.rd_due = 1'b1;
        t.wr_left = writes_per_group(s.ratio);
      end
      default:
      begin
        t.grp_left = s.pass_len;
        t.rd_due = 1'b1;
        t.wr_left = '0;
      end
    endcase
    return t;
  endfunction

  assign ctrl_wr = reg_wr && (reg_addr == traffic_generator_pkg::OFF_CTRL);
  assign clear = ctrl_wr && reg_wdata[traffic_generator_pkg::CTRL_CLEAR_BIT];
  assign accept = st_q.tx_valid && tx_ready;
  assign rd_done = cpl_valid && cpl_final && (st_q.outst != '0);
  assign rxq_pop = reg_rd &&
    (reg_addr == traffic_generator_pkg::OFF_RXQ_DATA);

  // ***********************************************************
  // received completion queue
  // ***********************************************************
  completion_queue #(
    .DATA_W(32),
    .DEPTH_LOG(RXQ_DEPTH_LOG)
  ) u_rxq (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(cpl_valid),
    .push_data(cpl_data),
    .push_stamp(st_q.elapsed),
    .pop(rxq_pop),
    .head_data(head_data),
    .head_stamp(head_stamp),
    .level(rxq_level)
  );

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    st_d = st_q;
    // register writes
    if (ctrl_wr)
    begin
      st_d.run = reg_wdata[traffic_generator_pkg::CTRL_RUN_BIT];
      st_d.thru = reg_wdata[traffic_generator_pkg::CTRL_THRU_BIT];
      st_d.mix = reg_wdata[traffic_generator_pkg::CTRL_MIX_LSB +: 2];
      st_d.size = reg_wdata[traffic_generator_pkg::CTRL_SIZE_LSB +: 3];
      st_d.ratio = reg_wdata[traffic_generator_pkg::CTRL_RATIO_LSB +: 2];
    end
    if (reg_wr && reg_addr == traffic_generator_pkg::OFF_LOOPS)
      st_d.loops = reg_wdata[15:0];
    if (reg_wr && reg_addr == traffic_generator_pkg::OFF_GAP)
      st_d.gap = reg_wdata[15:0];
    if (reg_wr && reg_addr == traffic_generator_pkg::OFF_PASS_LEN)
      st_d.pass_len = reg_wdata[15:0];
    if (reg_wr && reg_addr == traffic_generator_pkg::OFF_BASE)
      st_d.base = reg_wdata;
    if (!st_d.run)
      st_d.done = 1'b0;

    // transmit handshake: request held until the core takes it
    if (accept)
      st_d.tx_valid = 1'b0;

    // outstanding read bookkeeping
    if (rd_done)
      st_d.outst = st_q.outst - 1'b1;

    unique case (st_q.state)
      IDLE:
      begin
        if (st_q.run && !st_q.done)
        begin
          st_d = start_pass(st_d);
          st_d.loops_done = '0;
        end
      end
      ISSUE:
      begin
        if (!st_q.run)
        begin
          if (!st_q.tx_valid || accept)
            st_d.state = IDLE;
        end
        else if (st_q.tx_valid)
        begin
        end
        else if (st_q.grp_left == '0)
        begin
          // end of pass
          if (!st_q.thru &&
              (st_q.loops_done + 16'h0001) >= st_q.loops)
          begin
            st_d.done = 1'b1;
            st_d.state = IDLE;
          end
          else
          begin
            if (!st_q.thru)
              st_d.loops_done = st_q.loops_done + 16'h0001;
            if (st_q.gap != '0)
            begin
              st_d.state = GAP;
              st_d.gap_cnt = st_q.gap;
            end
            else
              st_d = start_pass(st_d);
          end
        end
        else if (st_q.rd_due)
        begin
          if (!np_credit_ok)
            st_d.np_wait = st_q.np_wait + 32'h1;
          else if (st_q.outst < read_limit(st_q.ratio))
          begin
            // read fetches host memory into the endpoint
            st_d.tx_valid = 1'b1;
            st_d.tx_is_write = 1'b0;
            st_d.tx_bytes = traffic_generator_pkg::read_bytes(st_q.size);
            st_d.tx_tag = st_q.tag;
            st_d.tx_addr = st_q.base + st_q.addr_off;
            st_d.addr_off = st_q.addr_off + 32'(st_d.tx_bytes);
            st_d.tag = st_q.tag + 4'h1;
            st_d.outst = st_d.outst + 1'b1;
            st_d.rd_due = 1'b0;
            if (st_q.wr_left == '0)
              st_d.grp_left = st_q.grp_left - 16'h0001;
          end
        end
        else if (st_q.wr_left != '0)
        begin
          if (!p_credit_ok)
            st_d.p_wait = st_q.p_wait + 32'h1;
          else
          begin
            // write carries endpoint data into host memory
            st_d.tx_valid = 1'b1;
            st_d.tx_is_write = 1'b1;
            st_d.tx_bytes = traffic_generator_pkg::write_bytes(st_q.size);
            st_d.tx_tag = '0;
            st_d.tx_addr = st_q.base + st_q.addr_off;
            st_d.addr_off = st_q.addr_off + 32'(st_d.tx_bytes);
            st_d.wr_left = st_q.wr_left - 16'h0001;
            if (st_q.wr_left == 16'h0001)
              st_d.grp_left = st_q.grp_left - 16'h0001;
          end
        end
        else
          st_d.grp_left = st_q.grp_left - 16'h0001;
        // reload the next read/write group of a combined pass, or the next read of a read-only pass
        if (st_q.run && !st_q.tx_valid && st_d.state == ISSUE &&
            st_d.grp_left != '0 && !st_d.rd_due && st_d.wr_left == '0 &&
            st_q.mix == 2'(traffic_generator_pkg::MIX_BOTH))
        begin
          st_d.rd_due = 1'b1;
          st_d.wr_left = writes_per_group(st_q.ratio);
        end
        else if (st_q.run && !st_q.tx_valid && st_d.state == ISSUE &&
            st_d.grp_left != '0 && !st_d.rd_due && st_d.wr_left == '0 &&
            st_q.mix != 2'(traffic_generator_pkg::MIX_WRITE))
          st_d.rd_due = 1'b1;
      end
      GAP:
      begin
        if (!st_q.run)
          st_d.state = IDLE;
        else if (st_q.gap_cnt <= 16'h0001)
          st_d = start_pass(st_d);
        else
          st_d.gap_cnt = st_q.gap_cnt - 16'h0001;
      end
      default:
        st_d.state = IDLE;
    endcase

    // performance counters; an event in the clearing cycle survives
    if (clear)
    begin
      st_d.np_wait = 32'(st_d.np_wait != st_q.np_wait);
      st_d.p_wait = 32'(st_d.p_wait != st_q.p_wait);
      st_d.sent = '0;
      st_d.rcvd = '0;
      st_d.elapsed = '0;
      st_d.stamp = '0;
    end
    if (accept && st_q.tx_is_write)
      st_d.sent = st_d.sent + 32'h1;
    if (st_q.busy)
      st_d.elapsed = st_d.elapsed + 32'h1;
    if (cpl_valid)
    begin
      st_d.rcvd = st_d.rcvd + 32'h1;
      st_d.stamp = st_q.elapsed;
    end
    st_d.busy = (st_d.state != IDLE);

    // read data, one cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        traffic_generator_pkg::OFF_CTRL:
          st_d.rdata = {22'h0, st_q.ratio, 1'b0, st_q.size, st_q.mix,
            st_q.thru, st_q.run};
        traffic_generator_pkg::OFF_LOOPS: st_d.rdata = {16'h0, st_q.loops};
        traffic_generator_pkg::OFF_GAP: st_d.rdata = {16'h0, st_q.gap};
        traffic_generator_pkg::OFF_PASS_LEN:
          st_d.rdata = {16'h0, st_q.pass_len};
        traffic_generator_pkg::OFF_BASE: st_d.rdata = st_q.base;
        traffic_generator_pkg::OFF_STATUS:
        begin
          st_d.rdata[0] = st_q.busy;
          st_d.rdata[1] = st_q.done;
          st_d.rdata[traffic_generator_pkg::STAT_LEVEL_LSB +:
            RXQ_DEPTH_LOG+1] = rxq_level;
          st_d.rdata[traffic_generator_pkg::STAT_OUTST_LSB +: 5] =
            st_q.outst;
        end
        traffic_generator_pkg::OFF_SENT: st_d.rdata = st_q.sent;
        traffic_generator_pkg::OFF_RCVD: st_d.rdata = st_q.rcvd;
        traffic_generator_pkg::OFF_ELAPSED: st_d.rdata = st_q.elapsed;
        traffic_generator_pkg::OFF_NP_WAIT: st_d.rdata = st_q.np_wait;
        traffic_generator_pkg::OFF_P_WAIT: st_d.rdata = st_q.p_wait;
        traffic_generator_pkg::OFF_STAMP: st_d.rdata = st_q.stamp;
        traffic_generator_pkg::OFF_RXQ_DATA: st_d.rdata = head_data;
        traffic_generator_pkg::OFF_RXQ_STAMP: st_d.rdata = head_stamp;
        default: st_d.rdata = '0;
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.state <= IDLE;
      st_q.loops <= traffic_generator_pkg::LOOPS_RESET;
      st_q.gap <= traffic_generator_pkg::GAP_RESET;
      st_q.pass_len <= traffic_generator_pkg::PASS_LEN_RESET;
      st_q.base <= traffic_generator_pkg::BASE_RESET;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata = st_q.rdata;
  assign tx_valid = st_q.tx_valid;
  assign tx_is_write = st_q.tx_is_write;
  assign tx_bytes = st_q.tx_bytes;
  assign tx_tag = st_q.tx_tag;
  assign tx_addr = st_q.tx_addr;
  assign test_running = st_q.busy;

  // ***********************************************************
  // checks
  // ***********************************************************
  a_read_size_cap: assert property (@(posedge clk_sys)
    disable iff (rst) tx_valid && !tx_is_write |-> tx_bytes <= 10'h200)
    else $error("read request too large");
  a_write_size_cap: assert property (@(posedge clk_sys)
    disable iff (rst) tx_valid && tx_is_write |-> tx_bytes <= 10'h080)
    else $error("write payload too large");
  a_pair_size_table: assert property (@(posedge clk_sys)
    disable iff (rst) $rose(tx_valid) && st_q.mix == 2'h2 |-> (tx_is_write ?
      tx_bytes == traffic_generator_pkg::write_bytes(st_q.size) :
      tx_bytes == traffic_generator_pkg::read_bytes(st_q.size)))
    else $error("size pair mismatch");
  a_single_read_wait: assert property (@(posedge clk_sys)
    disable iff (rst) st_q.ratio[1] == 1'b0 |-> st_q.outst <= 5'h01)
    else $error("second read issued before completion");
  a_tag_limit: assert property (@(posedge clk_sys)
    disable iff (rst) st_q.ratio == 2'h2 |-> st_q.outst <= 5'h04)
    else $error("more than four reads in flight");
  a_cycle_end: assert property (@(posedge clk_sys) disable iff (rst)
    st_q.busy && !st_q.thru && st_q.run ##1 !st_q.busy && st_q.run
      |-> st_q.done)
    else $error("cycle test stopped without finishing");
  a_gap_hold: assert property (@(posedge clk_sys) disable iff (rst)
    st_q.state == ISSUE ##1 st_q.state == GAP |->
      st_q.gap_cnt == $past(st_q.gap))
    else $error("gap loaded with wrong length");
  a_np_wait_count: assert property (@(posedge clk_sys)
    disable iff (rst) st_q.state == ISSUE && st_q.run && !st_q.tx_valid &&
      st_q.rd_due && st_q.grp_left != '0 && !np_credit_ok && !clear
      |=> st_q.np_wait == $past(st_q.np_wait) + 32'h1)
    else $error("non-posted wait not counted");
  a_idle_frozen: assert property (@(posedge clk_sys)
    disable iff (rst) !st_q.busy && !clear |=> $stable(st_q.elapsed))
    else $error("elapsed timer moved while idle");
  // a start written in this cycle may raise a request three cycles on
  a_stop_quiet: assert property (@(posedge clk_sys)
    disable iff (rst) !st_q.run && !ctrl_wr && !tx_valid |=>
      !tx_valid [*3])
    else $error("request issued while stopped");

endmodule

/* include/traffic_generator_pkg.sv */
package traffic_generator_pkg;

  // ***********************************************************
  // register map, byte addresses on the command port
  // ***********************************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_LOOPS = 6'h04;
  localparam logic [5:0] OFF_GAP = 6'h08;
  localparam logic [5:0] OFF_PASS_LEN = 6'h0C;
  localparam logic [5:0] OFF_BASE = 6'h10;
  localparam logic [5:0] OFF_STATUS = 6'h14;
  localparam logic [5:0] OFF_SENT = 6'h18;
  localparam logic [5:0] OFF_RCVD = 6'h1C;
  localparam logic [5:0] OFF_ELAPSED = 6'h20;
  localparam logic [5:0] OFF_NP_WAIT = 6'h24;
  localparam logic [5:0] OFF_P_WAIT = 6'h28;
  localparam logic [5:0] OFF_STAMP = 6'h2C;
  localparam logic [5:0] OFF_RXQ_DATA = 6'h30;
  localparam logic [5:0] OFF_RXQ_STAMP = 6'h34;

  // ***********************************************************
  // control and status field layout
  // ***********************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_THRU_BIT = 1;
  localparam int CTRL_MIX_LSB = 2;
  localparam int CTRL_SIZE_LSB = 4;
  localparam int CTRL_RATIO_LSB = 8;
  localparam int CTRL_CLEAR_BIT = 16;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_OUTST_LSB = 16;

  // ***********************************************************
  // reset values and sizes
  // ***********************************************************
  localparam logic [15:0] LOOPS_RESET = 16'h0001;
  localparam logic [15:0] GAP_RESET = 16'h0000;
  localparam logic [15:0] PASS_LEN_RESET = 16'h0001;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [9:0] MAX_READ_BYTES = 10'h200;
  localparam logic [9:0] MAX_WRITE_BYTES = 10'h080;
  localparam logic [4:0] LIMIT_ONE = 5'h01;
  localparam logic [4:0] LIMIT_FOUR = 5'h04;
  localparam logic [4:0] LIMIT_SIXTEEN = 5'h10;
  localparam logic [15:0] WR_PER_GROUP_ONE = 16'h0001;
  localparam logic [15:0] WR_PER_GROUP_FOUR = 16'h0004;
  localparam int CLK_PERIOD_NS = 40;

  typedef enum logic [1:0] {MIX_WRITE, MIX_READ, MIX_BOTH, MIX_SPARE}
    tlp_mix_t;
  typedef enum logic [1:0] {ratio_one_one, ratio_one_four,
    ratio_four_sixteen, ratio_sixteen_sixtyfour} ratio_t;

  // read request size per size selection
  function automatic logic [9:0] read_bytes(input logic [2:0] sel);
    unique case (sel)
      3'h0: read_bytes = 10'h200;
      3'h1: read_bytes = 10'h100;
      3'h2: read_bytes = 10'h080;
      3'h3: read_bytes = 10'h040;
      3'h4: read_bytes = 10'h020;
      default: read_bytes = 10'h010;
    endcase
  endfunction

  // write payload size paired with the same selection
  function automatic logic [9:0] write_bytes(input logic [2:0] sel);
    unique case (sel)
      3'h0, 3'h1, 3'h2: write_bytes = 10'h080;
      3'h3: write_bytes = 10'h040;
      3'h4: write_bytes = 10'h020;
      default: write_bytes = 10'h010;
    endcase
  endfunction

endpackage

/* rtl/completion_queue.sv */
`timescale 1ns/1ps
module completion_queue #(
  parameter int DATA_W = 32,
  parameter int DEPTH_LOG = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic [31:0] push_stamp,
  input wire logic pop,
  output logic [DATA_W-1:0] head_data,
  output logic [31:0] head_stamp,
  output logic [DEPTH_LOG:0] level
);

  localparam logic [DEPTH_LOG:0] FULL = (DEPTH_LOG+1)'(1 << DEPTH_LOG);

  typedef struct packed {
    logic [DEPTH_LOG-1:0] wp;
    logic [DEPTH_LOG-1:0] rp;
    logic [DEPTH_LOG:0] count;
  } q_st_t;

  q_st_t st_q;
  q_st_t st_d;
  logic [DATA_W+31:0] mem [0:(1<<DEPTH_LOG)-1];
  logic do_push;
  logic do_pop;

  // a full queue drops new entries; older ones stay for inspection
  assign do_push = push && (st_q.count != FULL);
  assign do_pop = pop && (st_q.count != '0);
  assign head_data = mem[st_q.rp][DATA_W+31:32];
  assign head_stamp = mem[st_q.rp][31:0];
  assign level = st_q.count;

  // pointer and fill count update
  always_comb
  begin
    st_d = st_q;
    if (do_push)
      st_d.wp = st_q.wp + 1'b1;
    if (do_pop)
      st_d.rp = st_q.rp + 1'b1;
    if (do_push && !do_pop)
      st_d.count = st_q.count + 1'b1;
    else if (!do_push && do_pop)
      st_d.count = st_q.count - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (do_push)
      mem[st_q.wp] <= {push_data, push_stamp};
  end

endmodule

/* testbench/core_model.sv */
`timescale 1ns/1ps
// ****
// core side: accepts tlps, returns completions
// ****
module core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic tx_is_write,
  input wire logic np_block,
  input wire logic p_block,
  output logic tx_ready,
  output logic np_credit_ok,
  output logic p_credit_ok,
  output logic cpl_valid,
  output logic cpl_final,
  output logic [31:0] cpl_data
);
  int owed = 0;
  logic [31:0] seq = 32'h5A00_0000;
  initial tx_ready = 1'b0;
  initial np_credit_ok = 1'b1;
  initial p_credit_ok = 1'b1;
  initial cpl_valid = 1'b0;
  initial cpl_final = 1'b0;
  initial cpl_data = 32'h0;
  // random stalls; data flips when idle so stale words never match
  always @(posedge clk_sys)
  begin
    tx_ready <= !rst && ($urandom % 4 != 0);
    np_credit_ok <= !np_block;
    p_credit_ok <= !p_block;
    cpl_valid <= 1'b0;
    cpl_final <= 1'b0;
    cpl_data <= ~cpl_data;
    if (tx_valid && tx_ready && !tx_is_write)
      owed++;
    if (owed > 0 && $urandom % 3 == 0)
    begin
      owed--;
      cpl_valid <= 1'b1;
      cpl_final <= 1'b1;
      cpl_data <= seq;
      seq++;
    end
  end
endmodule

/* testbench/tb_tlp_traffic_generator.sv */
`timescale 1ns/1ps
module tb_tlp_traffic_generator;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic np_block = 1'b0;
  logic p_block = 1'b0;
  logic [31:0] reg_rdata, tx_addr, cpl_data, last_rd;
  logic tx_valid, tx_ready, tx_is_write, np_credit_ok, p_credit_ok;
  logic cpl_valid, cpl_final, test_running;
  logic [9:0] tx_bytes;
  logic [3:0] tx_tag;
  logic rd_d = 1'b0;
  logic [1:0] mix = 2'h0;
  note_t notes[$];
  int errors = 0, checks = 0, inflight = 0, pos = 0, wr_seen = 0;
  int sel = 0, limit = 1, grp = 2, e0, tl = 0, per = 20;
  logic [31:0] bas = 32'h0;
  logic [31:0] adr = 32'h0;
  logic [3:0] tg = 4'h0;
  logic [9:0] rd_tab [6] = '{10'h200, 10'h100, 10'h080, 10'h040,
    10'h020, 10'h010};
  logic [9:0] wr_tab [6] = '{10'h080, 10'h080, 10'h080, 10'h040,
    10'h020, 10'h010};

  initial forever #20 clk_sys = ~clk_sys;

  traffic_generator dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_is_write(tx_is_write), .tx_bytes(tx_bytes),
    .tx_tag(tx_tag), .tx_addr(tx_addr), .np_credit_ok(np_credit_ok),
    .p_credit_ok(p_credit_ok), .cpl_valid(cpl_valid),
    .cpl_final(cpl_final), .cpl_data(cpl_data),
    .test_running(test_running));

  core_model core (.clk_sys(clk_sys), .rst(rst), .tx_valid(tx_valid),
    .tx_is_write(tx_is_write), .np_block(np_block), .p_block(p_block),
    .tx_ready(tx_ready), .np_credit_ok(np_credit_ok),
    .p_credit_ok(p_credit_ok), .cpl_valid(cpl_valid),
    .cpl_final(cpl_final), .cpl_data(cpl_data));

  // ****
  // shared tasks
  // ****
  task automatic check(input string what, input logic [31:0] s, x);
    checks++;
    if (s !== x)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // note first, then strobe; result lands two edges on
  task automatic rd(input logic [5:0] a, input logic [31:0] v, m);
    notes.push_back('{v, m});
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // stop bit plus clear, then start with the chosen mode
  task automatic go(input logic [1:0] m, r, input logic t);
    logic [31:0] c;
    sel = $urandom % 6;
    mix = m;
    limit = (r < 2'h2) ? 1 : (r == 2'h2 ? 4 : 16);
    grp = (r == 2'h0) ? 2 : 5;
    per = (m == 2'h2) ? limit * grp : 20;
    tl = 0;
    adr = 32'h0;
    pos = 0;
    c = {15'h0, 1'b1, 6'h0, r, 1'b0, 3'(sel), m, t, 1'b0};
    wr(traffic_generator_pkg::OFF_CTRL, c);
    wr_seen = 0;
    wr(traffic_generator_pkg::OFF_CTRL, {16'h0, c[15:1], 1'b1});
  endtask

  // bounded poll for done with no reads left in flight
  task automatic wait_done();
    int n;
    n = 0;
    last_rd = 32'h0;
    while (!(last_rd[1] === 1'b1 && last_rd[20:16] === 5'h00))
    begin
      n++;
      if (n > 3000)
      begin
        errors++;
        wrap_up();
      end
      rd(traffic_generator_pkg::OFF_STATUS, 32'h0, 32'h0);
    end
  endtask

  // ****
  // monitor: register answers and tlp stream
  // ****
  always @(posedge clk_sys)
  begin
    note_t n;
    logic [9:0] sz;
    logic k;
    rd_d <= reg_rd;
    if (rd_d)
    begin
      n = notes.pop_front();
      last_rd = reg_rdata;
      check("read data", reg_rdata & n.m, n.v);
    end
    if (cpl_valid && cpl_final)
      inflight--;
    if (tx_valid && tx_ready)
    begin
      sz = tx_is_write ? wr_tab[sel] : rd_tab[sel];
      k = mix == 2'h0 || (mix == 2'h2 && pos != 0);
      check("tag", tx_tag, tx_is_write ? 4'h0 : tg);
      check("address", tx_addr, bas + adr);
      if (tx_is_write)
        wr_seen++;
      else
      begin
        inflight++;
        tg++;
      end
      check("size", tx_bytes, sz);
      check("kind", tx_is_write, k);
      check("reads open", inflight <= limit, 32'h1);
      // offset restarts with every pass of the pattern
      adr = adr + sz;
      tl++;
      if (tl == per)
      begin
        tl = 0;
        adr = 32'h0;
      end
      pos = (pos + 1) % grp;
    end
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    int g, w;
    void'($urandom(32'h97f4));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(traffic_generator_pkg::OFF_CTRL, 32'h0, '1);
    rd(traffic_generator_pkg::OFF_LOOPS, 32'h1, '1);
    rd(traffic_generator_pkg::OFF_PASS_LEN, 32'h1, '1);
    rd(6'h3C, 32'h0, '1);
    wr(traffic_generator_pkg::OFF_LOOPS, 32'hABCD_FFFF);
    rd(traffic_generator_pkg::OFF_LOOPS, 32'h0000_FFFF, '1);
    wr(traffic_generator_pkg::OFF_LOOPS, 32'h2);
    wr(traffic_generator_pkg::OFF_PASS_LEN, 32'h14);
    wr(traffic_generator_pkg::OFF_GAP, 32'h5);
    bas = $urandom;
    wr(traffic_generator_pkg::OFF_BASE, bas);
    // every mix; reads once per ratio, then both, spare, write
    for (int i = 0; i < 7; i++)
    begin
      go(i < 4 ? 2'h1 : (i == 4 ? 2'h2 : 2'(i - 2)), 2'(i), 1'b0);
      wait_done();
      g = limit;
      w = grp - 1;
      e0 = mix == 2'h0 ? 40 : (mix == 2'h2 ? 2 * g * w : 0);
      check("writes", wr_seen, e0);
      check("stopped", test_running, 32'h0);
      rd(traffic_generator_pkg::OFF_SENT, e0, '1);
      e0 = mix == 2'h0 ? 0 : (mix == 2'h2 ? 2 * g : 40);
      rd(traffic_generator_pkg::OFF_RCVD, e0, '1);
    end
    rd(traffic_generator_pkg::OFF_ELAPSED, 32'h0, 32'h0);
    e0 = last_rd;
    check("elapsed runs", e0 > 0, 32'h1);
    rd(traffic_generator_pkg::OFF_ELAPSED, e0, '1);
    // throughput with credit stalls, then stop
    np_block <= 1'b1;
    go(2'h2, 2'h0, 1'b1);
    repeat (40) @(posedge clk_sys);
    check("np stall", wr_seen + inflight, 32'h0);
    check("running", test_running, 32'h1);
    p_block <= 1'b1;
    np_block <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check("p stall", wr_seen, 32'h0);
    p_block <= 1'b0;
    repeat (300) @(posedge clk_sys);
    wr(traffic_generator_pkg::OFF_CTRL, 32'h0);
    repeat (50) @(posedge clk_sys);
    check("looping", wr_seen > 8, 32'h1);
    check("halted", test_running, 32'h0);
    rd(traffic_generator_pkg::OFF_SENT, wr_seen, '1);
    rd(traffic_generator_pkg::OFF_NP_WAIT, 32'h0, 32'h0);
    check("np wait", last_rd >= 30, 32'h1);
    rd(traffic_generator_pkg::OFF_P_WAIT, 32'h0, 32'h0);
    check("p wait", last_rd >= 30, 32'h1);
    rd(traffic_generator_pkg::OFF_RXQ_DATA, 32'h5A00_0000, '1);
    rd(traffic_generator_pkg::OFF_RXQ_DATA, 32'h5A00_0001, '1);
    wrap_up();
  end
endmodule
